// ### common/pbfs_pkg.sv
// port b function select: register map, mode codes, pin function kinds, carriers
// assumes one clock domain and a 32-bit avalon-mm register slave
package pbfs_pkg;

   localparam int PBFS_PINS = 16;
   localparam int PBFS_AW = 4;

   // byte offsets of the register words
   localparam logic [3:0] PBFS_OFS_UPPER = 4'h0;
   localparam logic [3:0] PBFS_OFS_LOWER = 4'h4;
   localparam logic [3:0] PBFS_OFS_LEVEL = 4'h8;
   localparam logic [3:0] PBFS_OFS_DRIVE = 4'hc;

   localparam logic [15:0] PBFS_UPPER_RST = 16'h0000;
   localparam logic [15:0] PBFS_LOWER_RST = 16'h0000;

   // first pin whose field lives in the upper register
   localparam int PBFS_UPPER_FIRST_PIN = 8;
   // field of pin p sits at bit 2*(p mod 8) of its register
   localparam int PBFS_FIELD_W = 2;

   localparam logic [1:0] PBFS_MODE_GPIO = 2'h0;
   localparam logic [1:0] PBFS_MODE_ALT1 = 2'h1;
   localparam logic [1:0] PBFS_MODE_ALT2 = 2'h2;
   localparam logic [1:0] PBFS_MODE_PATTERN = 2'h3;

   // level a peripheral input sees while its pin serves another function
   localparam logic PBFS_IDLE_LEVEL = 1'b1;

   typedef enum logic [1:0] {
      PBFS_K_RSVD,
      PBFS_K_IN,
      PBFS_K_OUT,
      PBFS_K_IO
   } pbfs_kind_t;

   // peripheral side values that may be driven onto pins
   typedef struct packed {
      logic [15:0] pattern;
      logic [1:0] serial_clk;
      logic [1:0] serial_tx;
      logic timer_cmp_out_xb4;
      logic timer_cmp_out_xa4;
      logic timer_capcmp_b4;
      logic timer_capcmp_a4;
   } pbfs_periph_drv_t;

   // pin levels handed to peripherals; ext_int[0] is line 4
   typedef struct packed {
      logic [3:0] ext_int;
      logic [1:0] serial_clk;
      logic [1:0] serial_rx;
      logic timer_ext_clk_d;
      logic timer_ext_clk_c;
      logic timer_capcmp_b4;
      logic timer_capcmp_a4;
   } pbfs_periph_rcv_t;

   localparam pbfs_periph_rcv_t PBFS_RCV_IDLE = '1;

   // what mode code 01 or 10 means on a given pin
   function automatic pbfs_kind_t pbfs_kind(input int pin, input logic [1:0] code);
      pbfs_kind_t k;
      k = PBFS_K_RSVD;
      if (code == PBFS_MODE_ALT1) begin
         if (pin >= 12 || pin == 7 || pin == 6) k = PBFS_K_IN;
      end else if (code == PBFS_MODE_ALT2) begin
         if (pin == 13 || pin == 12 || pin == 5 || pin == 4) k = PBFS_K_IO;
         else if (pin == 11 || pin == 9 || pin == 7 || pin == 6) k = PBFS_K_OUT;
         else if (pin == 10 || pin == 8) k = PBFS_K_IN;
      end
      return k;
   endfunction

endpackage

// ### verilog/pbfs_pin_cell.sv
// one multiplexed pin: turns a two-bit mode into drive value and enable
// assumes mode, direction and peripheral data all on the system clock
`timescale 1ns/1ps
module pbfs_pin_cell import pbfs_pkg::*; #(
   parameter pbfs_kind_t KIND_A = PBFS_K_RSVD,
   parameter pbfs_kind_t KIND_B = PBFS_K_RSVD
) (
   input wire logic [1:0] mode_in,
   input wire logic dir_in,
   input wire logic gpio_data_in,
   input wire logic alt_a_data_in,
   input wire logic alt_b_data_in,
   input wire logic pattern_in,
   output logic pin_drive_out,
   output logic pin_oe_out,
   output logic sel_a_out,
   output logic sel_b_out
);

   pbfs_kind_t kind;
   logic is_pat;
   logic alt_data;

   // reserved codes fall back to general i/o
   assign kind = pbfs_kind_t'((mode_in == PBFS_MODE_ALT1) ? KIND_A :
                              (mode_in == PBFS_MODE_ALT2) ? KIND_B : PBFS_K_RSVD);
   assign is_pat = (mode_in == PBFS_MODE_PATTERN);
   assign alt_data = (mode_in == PBFS_MODE_ALT1) ? alt_a_data_in : alt_b_data_in;

   assign sel_a_out = (mode_in == PBFS_MODE_ALT1) && (KIND_A != PBFS_K_RSVD);
   assign sel_b_out = (mode_in == PBFS_MODE_ALT2) && (KIND_B != PBFS_K_RSVD);

   // gpio and bidirectional functions follow the direction bit
   assign pin_oe_out = is_pat ? 1'b1 :
                       (kind == PBFS_K_IN) ? 1'b0 :
                       (kind == PBFS_K_OUT) ? 1'b1 : dir_in;
   assign pin_drive_out = is_pat ? pattern_in :
                          (kind == PBFS_K_IN) ? 1'b0 :
                          (kind == PBFS_K_RSVD) ? gpio_data_in : alt_data;

endmodule // pbfs_pin_cell

// ### verilog/pbfs_avalon_regs.sv
// avalon-mm slave holding the two function select words and two status words
// assumes byte addressing and a master that holds its request while waitrequest is high
`timescale 1ns/1ps
module pbfs_avalon_regs import pbfs_pkg::*; (
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic [PBFS_AW-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [15:0] pin_level_in,
   input wire logic [15:0] pin_oe_in,
   output logic [15:0] upper_out,
   output logic [15:0] lower_out,
   output logic wr_accept_out
);

   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [15:0] upper_q;
   logic [15:0] upper_d;
   logic [15:0] lower_q;
   logic [15:0] lower_d;
   logic req;
   logic hit_upper;
   logic hit_lower;
   logic hit_level;
   logic hit_drive;
   logic [15:0] wmask;

   // one wait state on every access
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_accept_out = avs_write_in & ack_q;

   assign hit_upper = (avs_address_in == PBFS_OFS_UPPER);
   assign hit_lower = (avs_address_in == PBFS_OFS_LOWER);
   assign hit_level = (avs_address_in == PBFS_OFS_LEVEL);
   assign hit_drive = (avs_address_in == PBFS_OFS_DRIVE);

   assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign upper_d = (wr_accept_out && hit_upper) ?
                    ((upper_q & ~wmask) | (avs_writedata_in[15:0] & wmask)) : upper_q;
   assign lower_d = (wr_accept_out && hit_lower) ?
                    ((lower_q & ~wmask) | (avs_writedata_in[15:0] & wmask)) : lower_q;

   // unmapped offsets read as zero
   assign rdata_d = hit_upper ? {16'h0000, upper_q} :
                    hit_lower ? {16'h0000, lower_q} :
                    hit_level ? {16'h0000, pin_level_in} :
                    hit_drive ? {16'h0000, pin_oe_in} : 32'h0000_0000;

   // only the power-on reset clears the select words
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         upper_q <= PBFS_UPPER_RST; // R13
         lower_q <= PBFS_LOWER_RST; // R13
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= (avs_read_in && !ack_q) ? rdata_d : rdata_q;
         upper_q <= upper_d;
         lower_q <= lower_d;
      end
   end

   assign avs_readdata_out = rdata_q;
   assign upper_out = upper_q;
   assign lower_out = lower_q;

endmodule // pbfs_avalon_regs

// ### verilog/pbfs_top.sv
// port b pin function select: register slave, sixteen pin muxes, pin synchroniser
// assumes pins are asynchronous; gpio data, direction and peripherals share mclk_in
//
// Function
// R1: pin 15 field upper[15:14]: gpio, ext int 7, reserved, pattern 15.
// R2: pin 14 field upper[13:12]: gpio, ext int 6, reserved, pattern 14.
// R3: pin 13 field upper[11:10]: gpio, ext int 5, serial clock 1, pattern 13.
// R4: pin 12 field upper[9:8]: gpio, ext int 4, serial clock 0, pattern 12.
// R5: pin 11 field upper[7:6]: gpio, reserved, transmit data 1, pattern 11.
// R6: pin 10 field upper[5:4]: gpio, reserved, receive data 1, pattern 10.
// R7: pin 9 field upper[3:2]: gpio, reserved, transmit data 0, pattern 9.
// R8: pin 8 field upper[1:0]: gpio, reserved, receive data 0, pattern 8.
// R9: pin 7 field lower[15:14]: gpio, timer clock d, compare xb4, pattern 7.
// R10: pin 6 field lower[13:12]: gpio, timer clock c, compare xa4, pattern 6.
// R11: pin 5 field lower[11:10]: gpio, reserved, capture/compare b4, pattern 5.
// R12: pin 4 field lower[9:8]: gpio, reserved, capture/compare a4, pattern 4.
// R13: both select words clear only on power-on reset and otherwise hold.
// R14: gpio, capture/compare and serial clock pins take direction bit as enable.
// R15: software avoids reserved codes; hardware treats them as general i/o.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module pbfs_top import pbfs_pkg::*; (
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic [PBFS_AW-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe_out,
   input wire logic [15:0] gpio_data_in,
   input wire logic [15:0] direction_in,
   output logic [15:0] gpio_level_out,
   input wire pbfs_periph_drv_t periph_in,
   output pbfs_periph_rcv_t periph_out
);

   logic [15:0] sync1_q;
   logic [15:0] sync2_q;
   logic [15:0] upper;
   logic [15:0] lower;
   logic [31:0] sel_cat;
   logic wr_accept;
   logic [15:0] drive_d;
   logic [15:0] oe_d;
   logic [15:0] drive_q;
   logic [15:0] oe_q;
   logic [15:0] sel_a;
   logic [15:0] sel_b;
   logic [15:0] alt_a_data;
   logic [15:0] alt_b_data;
   pbfs_periph_rcv_t rcv_d;
   pbfs_periph_rcv_t rcv_q;

   pbfs_avalon_regs u_regs (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .pin_level_in(sync2_q),
      .pin_oe_in(oe_q),
      .upper_out(upper),
      .lower_out(lower),
      .wr_accept_out(wr_accept)
   );

   // pin p uses bits 2p+1:2p of the joined words
   assign sel_cat = {upper, lower};

   // every alternate function with code 01 is an input
   assign alt_a_data = 16'h0000;
   assign alt_b_data = {2'b00,
                        periph_in.serial_clk[1],
                        periph_in.serial_clk[0],
                        periph_in.serial_tx[1],
                        1'b0,
                        periph_in.serial_tx[0],
                        1'b0,
                        periph_in.timer_cmp_out_xb4,
                        periph_in.timer_cmp_out_xa4,
                        periph_in.timer_capcmp_b4,
                        periph_in.timer_capcmp_a4,
                        4'h0};

   for (genvar p = 0; p < PBFS_PINS; p++) begin : g_pin
      pbfs_pin_cell #(
         .KIND_A(pbfs_kind(p, PBFS_MODE_ALT1)),
         .KIND_B(pbfs_kind(p, PBFS_MODE_ALT2))
      ) u_cell (
         .mode_in(sel_cat[PBFS_FIELD_W*p +: PBFS_FIELD_W]), // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R15
         .dir_in(direction_in[p]), // R14
         .gpio_data_in(gpio_data_in[p]),
         .alt_a_data_in(alt_a_data[p]),
         .alt_b_data_in(alt_b_data[p]),
         .pattern_in(periph_in.pattern[p]),
         .pin_drive_out(drive_d[p]),
         .pin_oe_out(oe_d[p]),
         .sel_a_out(sel_a[p]),
         .sel_b_out(sel_b[p])
      );
   end

   // route synchronised pin levels to the peripheral owning each pin
   assign rcv_d.ext_int[3] = sel_a[15] ? sync2_q[15] : PBFS_IDLE_LEVEL; // R1
   assign rcv_d.ext_int[2] = sel_a[14] ? sync2_q[14] : PBFS_IDLE_LEVEL; // R2
   assign rcv_d.ext_int[1] = sel_a[13] ? sync2_q[13] : PBFS_IDLE_LEVEL; // R3
   assign rcv_d.ext_int[0] = sel_a[12] ? sync2_q[12] : PBFS_IDLE_LEVEL; // R4
   assign rcv_d.serial_clk[1] = sel_b[13] ? sync2_q[13] : PBFS_IDLE_LEVEL; // R3
   assign rcv_d.serial_clk[0] = sel_b[12] ? sync2_q[12] : PBFS_IDLE_LEVEL; // R4
   assign rcv_d.serial_rx[1] = sel_b[10] ? sync2_q[10] : PBFS_IDLE_LEVEL; // R6
   assign rcv_d.serial_rx[0] = sel_b[8] ? sync2_q[8] : PBFS_IDLE_LEVEL; // R8
   assign rcv_d.timer_ext_clk_d = sel_a[7] ? sync2_q[7] : PBFS_IDLE_LEVEL; // R9
   assign rcv_d.timer_ext_clk_c = sel_a[6] ? sync2_q[6] : PBFS_IDLE_LEVEL; // R10
   assign rcv_d.timer_capcmp_b4 = sel_b[5] ? sync2_q[5] : PBFS_IDLE_LEVEL; // R11
   assign rcv_d.timer_capcmp_a4 = sel_b[4] ? sync2_q[4] : PBFS_IDLE_LEVEL; // R12

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // registered pad outputs; all pins are inputs while reset is held
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         drive_q <= 16'h0000;
         oe_q <= 16'h0000;
         rcv_q <= PBFS_RCV_IDLE;
      end else begin
         drive_q <= drive_d;
         oe_q <= oe_d;
         rcv_q <= rcv_d;
      end
   end

   assign pin_out = drive_q;
   assign pin_oe_out = oe_q;
   assign periph_out = rcv_q;
   assign gpio_level_out = sync2_q;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence wr_upper_s;
      wr_accept && (avs_address_in == PBFS_OFS_UPPER) && avs_byteenable_in[1];
   endsequence

   sequence pat14_write_s;
      wr_upper_s ##0 (avs_writedata_in[13:12] == PBFS_MODE_PATTERN);
   endsequence

   sequence pin14_pattern_s;
      pin_oe_out[14] ##0 (pin_out[14] == $past(periph_in.pattern[14]));
   endsequence

   pin15_irq_a: assert property ( // R1
      (upper[15:14] == PBFS_MODE_ALT1) |=>
      !pin_oe_out[15] && (periph_out.ext_int[3] == $past(sync2_q[15])))
      else $error("pin 15 not routed to external interrupt 7");

   pin15_rsvd_a: assert property ( // R15
      (upper[15:14] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[15] == $past(direction_in[15])) &&
      (pin_out[15] == $past(gpio_data_in[15])) && periph_out.ext_int[3])
      else $error("reserved code on pin 15 not treated as gpio");

   pat14_write_a: assert property ( // R2
      pat14_write_s |=> ##1 pin14_pattern_s)
      else $error("pattern code written for pin 14 did not reach the pin");

   pin13_sck_a: assert property ( // R3
      (upper[11:10] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[13] == $past(direction_in[13])) &&
      (pin_out[13] == $past(periph_in.serial_clk[1])) &&
      (periph_out.serial_clk[1] == $past(sync2_q[13])))
      else $error("pin 13 serial clock 1 routing wrong");

   pin12_irq_a: assert property ( // R4
      (upper[9:8] == PBFS_MODE_ALT1) |=>
      !pin_oe_out[12] && (periph_out.ext_int[0] == $past(sync2_q[12])) &&
      periph_out.serial_clk[0])
      else $error("pin 12 not routed to external interrupt 4");

   pin11_tx_a: assert property ( // R5
      (upper[7:6] == PBFS_MODE_ALT2) |=>
      pin_oe_out[11] && (pin_out[11] == $past(periph_in.serial_tx[1])))
      else $error("pin 11 does not drive transmit data 1");

   pin10_rx_a: assert property ( // R6
      (upper[5:4] == PBFS_MODE_ALT2) |=>
      !pin_oe_out[10] && (periph_out.serial_rx[1] == $past(sync2_q[10])))
      else $error("pin 10 not routed to receive data 1");

   pin9_tx_a: assert property ( // R7
      (upper[3:2] == PBFS_MODE_ALT2) |=>
      pin_oe_out[9] && (pin_out[9] == $past(periph_in.serial_tx[0])))
      else $error("pin 9 does not drive transmit data 0");

   pin8_rx_a: assert property ( // R8
      (upper[1:0] != PBFS_MODE_ALT2) |=> periph_out.serial_rx[0])
      else $error("receive data 0 not idle while pin 8 serves another function");

   pin7_cmp_a: assert property ( // R9
      (lower[15:14] == PBFS_MODE_ALT2) |=>
      pin_oe_out[7] && (pin_out[7] == $past(periph_in.timer_cmp_out_xb4)) &&
      periph_out.timer_ext_clk_d)
      else $error("pin 7 does not drive compare xb4");

   pin6_clk_a: assert property ( // R10
      (lower[13:12] == PBFS_MODE_ALT1) |=>
      !pin_oe_out[6] && (periph_out.timer_ext_clk_c == $past(sync2_q[6])))
      else $error("pin 6 not routed to timer clock c");

   pin5_cap_a: assert property ( // R11
      (lower[11:10] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[5] == $past(direction_in[5])) &&
      (pin_out[5] == $past(periph_in.timer_capcmp_b4)) &&
      (periph_out.timer_capcmp_b4 == $past(sync2_q[5])))
      else $error("pin 5 capture/compare b4 routing wrong");

   pin4_pat_a: assert property ( // R12
      (lower[9:8] == PBFS_MODE_PATTERN) |=>
      pin_oe_out[4] && (pin_out[4] == $past(periph_in.pattern[4])) &&
      periph_out.timer_capcmp_a4)
      else $error("pin 4 pattern output wrong");

   sel_hold_a: assert property ( // R13
      !wr_accept |=> $stable(upper) && $stable(lower))
      else $error("select word changed without an accepted write");

   gpio_dir_a: assert property ( // R14
      (lower[7:6] == PBFS_MODE_GPIO) |=>
      (pin_oe_out[3] == $past(direction_in[3])) &&
      (pin_out[3] == $past(gpio_data_in[3])))
      else $error("gpio pin 3 ignores direction or data");

   rd_wait_a: assert property ( // R13
      (avs_read_in && !avs_waitrequest_out && (avs_address_in == PBFS_OFS_LOWER)) |->
      (avs_readdata_out == {16'h0000, lower}))
      else $error("lower select word read back wrong");

   pin14_rsvd_a: assert property ( // R2
      (upper[13:12] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[14] == $past(direction_in[14])) &&
      (pin_out[14] == $past(gpio_data_in[14])) && periph_out.ext_int[2])
      else $error("reserved code on pin 14 not treated as gpio");

   pin12_sck_a: assert property ( // R4
      (upper[9:8] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[12] == $past(direction_in[12])) &&
      (pin_out[12] == $past(periph_in.serial_clk[0])) &&
      (periph_out.serial_clk[0] == $past(sync2_q[12])))
      else $error("pin 12 serial clock 0 routing wrong");

   pin11_rsvd_a: assert property ( // R5
      (upper[7:6] == PBFS_MODE_ALT1) |=>
      (pin_oe_out[11] == $past(direction_in[11])) &&
      (pin_out[11] == $past(gpio_data_in[11])))
      else $error("reserved code on pin 11 not treated as gpio");

   pin9_pat_a: assert property ( // R7
      (upper[3:2] == PBFS_MODE_PATTERN) |=>
      pin_oe_out[9] && (pin_out[9] == $past(periph_in.pattern[9])))
      else $error("pin 9 pattern output wrong");

   pin8_pat_a: assert property ( // R8
      (upper[1:0] == PBFS_MODE_PATTERN) |=>
      pin_oe_out[8] && (pin_out[8] == $past(periph_in.pattern[8])))
      else $error("pin 8 pattern output wrong");

   pin7_clk_a: assert property ( // R9
      (lower[15:14] == PBFS_MODE_ALT1) |=>
      !pin_oe_out[7] && (periph_out.timer_ext_clk_d == $past(sync2_q[7])))
      else $error("pin 7 not routed to timer clock d");

   pin6_cmp_a: assert property ( // R10
      (lower[13:12] == PBFS_MODE_ALT2) |=>
      pin_oe_out[6] && (pin_out[6] == $past(periph_in.timer_cmp_out_xa4)) &&
      periph_out.timer_ext_clk_c)
      else $error("pin 6 does not drive compare xa4");

   pin4_cap_a: assert property ( // R12
      (lower[9:8] == PBFS_MODE_ALT2) |=>
      (pin_oe_out[4] == $past(direction_in[4])) &&
      (pin_out[4] == $past(periph_in.timer_capcmp_a4)) &&
      (periph_out.timer_capcmp_a4 == $past(sync2_q[4])))
      else $error("pin 4 capture/compare a4 routing wrong");

   reset_clear_a: assert property ( // R13
      !$past(arst_n_in) |->
      (upper == PBFS_UPPER_RST) && (lower == PBFS_LOWER_RST) &&
      (pin_oe_out == 16'h0000) && (periph_out == PBFS_RCV_IDLE))
      else $error("select words or pads not cleared by reset");

endmodule // pbfs_top

// ### verification/pbfs_pin_model.sv
// pin model: outside world on the sixteen port b pins
// assumes an external source that drives every pin the device leaves undriven
`timescale 1ns/1ps
module pbfs_pin_model (
   input wire logic [15:0] drive_in,
   input wire logic [15:0] oe_in,
   input wire logic [15:0] ext_level_in,
   output logic [15:0] level_out
);
   // device wins where it drives, else the external source
   assign level_out = (oe_in & drive_in) | (~oe_in & ext_level_in);
endmodule // pbfs_pin_model

// ### verification/pbfs_top_bench.sv
// bench: table of pins and mode codes, then register, byte lane and reset cases
// assumes pbfs_top with one wait state on its avalon-mm slave and the pin model beside it
`timescale 1ns/1ps
module pbfs_top_bench import pbfs_pkg::*;;
   typedef struct {int pin; int k1; int b1; int k2; int b2;} pbfs_row_t;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [PBFS_AW-1:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wait_req;
   logic [15:0] pin_lvl, pin_drv, pin_oe, lvl;
   logic [15:0] gpio_d = '0;
   logic [15:0] dir = '0;
   logic [15:0] ext = '0;
   pbfs_periph_drv_t drv = '0;
   pbfs_periph_rcv_t rcv;
   int err_total = 0;
   int comparisons = 0;
   // kind: 0 reserved, 1 input, 2 output, 3 bidirectional; b = periph_out bit
   pbfs_row_t rows [12] = '{
      '{15, 1, 11, 0, 0},
      '{14, 1, 10, 0, 0},
      '{13, 1, 9, 3, 7},
      '{12, 1, 8, 3, 6},
      '{11, 0, 0, 2, 0},
      '{10, 0, 0, 1, 5},
      '{9, 0, 0, 2, 0},
      '{8, 0, 0, 1, 4},
      '{7, 1, 3, 2, 0},
      '{6, 1, 2, 2, 0},
      '{5, 0, 0, 3, 1},
      '{4, 0, 0, 3, 0}
   };

   initial begin
      forever #2 mclk = ~mclk;
   end

   pbfs_top uut (
      .mclk_in(mclk), .arst_n_in(arst_n), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .pin_in(pin_lvl),
      .pin_out(pin_drv), .pin_oe_out(pin_oe), .gpio_data_in(gpio_d), .direction_in(dir),
      .gpio_level_out(lvl), .periph_in(drv), .periph_out(rcv)
   );

   pbfs_pin_model model_i (
      .drive_in(pin_drv), .oe_in(pin_oe), .ext_level_in(ext), .level_out(pin_lvl)
   );

   task automatic conclude();
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // one access; request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdata <= d;
      do begin
         @(posedge mclk);
      end while (wait_req !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, '0, q);
      chk(q, exp);
   endtask

   task automatic run_case(input pbfs_row_t r, input int c, input int d);
      int k, b, sh;
      logic oe, lv;
      logic [3:0] a;
      logic [31:0] q;
      pbfs_periph_rcv_t exp_rcv;
      k = (c == 1) ? r.k1 : (c == 2) ? r.k2 : (c == 3) ? 4 : 0;
      b = (c == 1) ? r.b1 : r.b2;
      sh = 2 * (r.pin % 8);
      a = (r.pin >= 8) ? PBFS_OFS_UPPER : PBFS_OFS_LOWER;
      // selected group drives 1, others 0: gpio data, pattern, or all eight serial and timer outputs
      gpio_d <= (k == 0) ? 16'hffff : 16'h0000;
      drv <= {((k == 4) ? 16'hffff : 16'h0000), ((k == 2 || k == 3) ? 8'hff : 8'h00)};
      dir <= (d != 0) ? 16'hffff : 16'h0000;
      bus(1'b1, a, 32'(c) << sh, q);
      rd_chk(a, 32'(c) << sh);
      oe = (k == 1) ? 1'b0 : (k == 2 || k == 4) ? 1'b1 : 1'(d);
      lv = oe;
      exp_rcv = PBFS_RCV_IDLE;
      if (k == 1 || k == 3) exp_rcv[b] = lv;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk(32'(pin_oe[r.pin]), 32'(oe));
      if (oe) chk(32'(pin_drv[r.pin]), 32'h1);
      chk(32'(lvl[r.pin]), 32'(lv));
      chk(32'(rcv), 32'(exp_rcv));
      @(posedge mclk);
   endtask

   initial begin
      logic [31:0] q;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      chk(32'(pin_oe), 32'h0);
      rd_chk(PBFS_OFS_UPPER, 32'(PBFS_UPPER_RST));
      rd_chk(PBFS_OFS_LOWER, 32'(PBFS_LOWER_RST));
      foreach (rows[i]) begin
         for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
               run_case(rows[i], c, d);
            end
         end
      end
      // low byte lane only, then a write to a read-only word
      dir <= 16'h0000;
      bus(1'b1, PBFS_OFS_UPPER, 32'h0, q);
      be <= 4'h1;
      bus(1'b1, PBFS_OFS_UPPER, 32'hffff_ffff, q);
      be <= 4'hf;
      bus(1'b1, PBFS_OFS_LEVEL, 32'hffff_ffff, q);
      rd_chk(PBFS_OFS_UPPER, 32'h0000_00ff);
      bus(1'b1, PBFS_OFS_LOWER, 32'h0000_ffff, q);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(32'(pin_oe), 32'h0000_0fff);
      rd_chk(PBFS_OFS_DRIVE, 32'h0000_0fff);
      // reset in mid-run clears both words
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      chk(32'(pin_oe), 32'h0);
      chk(32'(pin_drv), 32'h0);
      rd_chk(PBFS_OFS_UPPER, 32'h0);
      rd_chk(PBFS_OFS_LOWER, 32'h0);
      conclude();
   end

   initial begin
      #50000;
      err_total++;
      conclude();
   end
endmodule // pbfs_top_bench
